// [hw/sow_top.sv]
// Overview of operation
// - options register takes only the first write after reset; later writes dropped
// - options readable anytime; bits three and two read zero
// - watchdog enable resets to one; zero disables the watchdog
// - watchdog timeout bit resets to one; selects 2^13 or 2^18 cycles
// - stop permit resets to zero; stop then forces illegal-opcode reset
// - debug pin select resets to one; one debug pin, zero output pin
// - identification high byte is read-only; bits 7:4 hold revision
// - twelve-bit part number split over high nibble and low byte
// - wakeup flag read-only; set on timeout, zero when none pending
// - writing one to acknowledge clears flag; reads zero
// - wakeup clock select: zero internal oscillator, one external source
// - wakeup interrupt enable gates a set flag onto a request
// - period code zero stops the wakeup timer for either source
// - internal source codes give 8 to 1024 ms intervals
// - external source codes divide by 256 up to 32768
// - unimplemented wakeup register bits read zero, writes ignored
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "sow_cfg.svh"
module sow_top
#(
  parameter int INT_TICK_CYCLES = `SOW_INT_TICK_NS / `SOW_CLK_PERIOD_NS,
  parameter logic [3:0] REVISION = 4'h3, // arbitrary value
  parameter logic [11:0] PART_NUMBER = 12'h5a7 // arbitrary value
)
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic watchdog_enable_o,
  output logic watchdog_long_timeout_o,
  output logic [18:0] watchdog_timeout_cycles_o,
  input wire logic stop_request_i,
  output logic stop_enter_o,
  output logic illegal_stop_reset_o,
  input wire logic ext_clk_i,
  output logic wakeup_irq_o,
  output logic debug_pin_select_o,
  input wire logic port_g_bit_zero_output_i,
  input wire logic bdm_out_i,
  input wire logic bdm_oe_i,
  output logic bdm_pin_o,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  sow_pkg::sow_apb_state_t apb_state_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [7:0] opt_r;
  logic opt_written_r;
  logic wk_flag_r;
  logic wk_clksel_r;
  logic wk_ie_r;
  sow_pkg::sow_period_t wk_period_r;
  logic [7:0] evt_status_r;
  logic [7:0] evt_mask_r;
  logic [7:0] evt_set;
  logic irq_r;
  logic wakeup_irq_r;
  logic [18:0] wdog_cycles_r;
  logic stop_enter_r;
  logic bad_stop_r;
  logic ext_prev_r;
  logic [16:0] int_cnt_r;
  logic int_tick;
  logic ext_edge;
  logic restart;
  logic wr_commit;
  logic hit;
  logic [7:0] rd_byte;
  logic [7:0] wdat;

  sow_wake_if wake ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // true when the byte address is the aligned word of a register index
  function automatic logic sow_sel(input logic [15:0] addr, input logic [15:0] index);
    return (addr[1:0] == 2'h0) && ({2'h0, addr[15:2]} == index);
  endfunction : sow_sel

  assign wdat = pwdata_i[7:0];

  // read mux; registers are byte wide in the low lane
  always_comb
  begin
    hit = 1'b1;
    rd_byte = 8'h00;
    if (sow_sel(paddr_i, `SOW_IDX_OPTIONS))
    begin
      rd_byte = opt_r & `SOW_OPT_IMPL;
    end
    else if (sow_sel(paddr_i, `SOW_IDX_REV_HIGH))
    begin
      rd_byte = {REVISION, PART_NUMBER[11:8]};
    end
    else if (sow_sel(paddr_i, `SOW_IDX_PART_LOW))
    begin
      rd_byte = PART_NUMBER[7:0];
    end
    else if (sow_sel(paddr_i, `SOW_IDX_WAKEUP))
    begin
      rd_byte = 8'h00; // ack and spare bits read zero
      rd_byte[`SOW_WK_FLAG] = wk_flag_r;
      rd_byte[`SOW_WK_CLKSEL] = wk_clksel_r;
      rd_byte[`SOW_WK_IE] = wk_ie_r;
      rd_byte[`SOW_WK_PER_HI:`SOW_WK_PER_LO] = wk_period_r;
    end
    else if (sow_sel(paddr_i, `SOW_IDX_EVT_STATUS))
    begin
      rd_byte = evt_status_r;
    end
    else if (sow_sel(paddr_i, `SOW_IDX_EVT_MASK))
    begin
      rd_byte = evt_mask_r;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer from registers

  // a write lands at the edge where the master sees pready high
  assign wr_commit = pready_r && psel_i && penable_i && pwrite_i && hit;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      apb_state_r <= sow_pkg::SOW_APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      case (apb_state_r)
        sow_pkg::SOW_APB_IDLE:
        begin
          if (psel_i && penable_i)
          begin
            apb_state_r <= sow_pkg::SOW_APB_ANSWER;
            pready_r <= 1'b1;
            pslverr_r <= ~hit; // unmapped or misaligned
            prdata_r <= (pwrite_i || !hit) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
          end
        end
        default:
        begin
          apb_state_r <= sow_pkg::SOW_APB_IDLE;
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-once system options

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      opt_r <= `SOW_OPT_RESET;
      opt_written_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_commit && sow_sel(paddr_i, `SOW_IDX_OPTIONS) && !opt_written_r)
      begin
        opt_r <= wdat & `SOW_OPT_IMPL;
        opt_written_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wakeup status and control

  // restart the interval when a write changes source or period
  assign restart = wr_commit && sow_sel(paddr_i, `SOW_IDX_WAKEUP)
    && ((wdat[`SOW_WK_CLKSEL] != wk_clksel_r)
    || (wdat[`SOW_WK_PER_HI:`SOW_WK_PER_LO] != wk_period_r));

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      wk_clksel_r <= 1'(`SOW_WK_RESET >> `SOW_WK_CLKSEL);
      wk_ie_r <= 1'(`SOW_WK_RESET >> `SOW_WK_IE);
      wk_period_r <= sow_pkg::sow_period_t'(`SOW_WK_RESET);
    end
    else if (ce_i)
    begin
      if (wr_commit && sow_sel(paddr_i, `SOW_IDX_WAKEUP))
      begin
        wk_clksel_r <= wdat[`SOW_WK_CLKSEL];
        wk_ie_r <= wdat[`SOW_WK_IE];
        wk_period_r <= wdat[`SOW_WK_PER_HI:`SOW_WK_PER_LO];
      end
    end
  end

  // flag: a timeout in the acknowledge cycle wins
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      wk_flag_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wake.timeout)
      begin
        wk_flag_r <= 1'b1;
      end
      else if (wr_commit && sow_sel(paddr_i, `SOW_IDX_WAKEUP) && wdat[`SOW_WK_ACK])
      begin
        wk_flag_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wakeup time base

  // nominal 1 ms tick for the internal oscillator
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      int_cnt_r <= 17'h0_0000;
    end
    else if (ce_i)
    begin
      if (int_tick || restart)
      begin
        int_cnt_r <= 17'h0_0000;
      end
      else
      begin
        int_cnt_r <= int_cnt_r + 17'h0_0001;
      end
    end
  end

  assign int_tick = (int_cnt_r == 17'(INT_TICK_CYCLES - 1));

  // rising edge of the external source, which is synchronous
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      ext_prev_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ext_prev_r <= ext_clk_i;
    end
  end

  assign ext_edge = ext_clk_i && !ext_prev_r;

  // source selection toward the divider
  assign wake.src = wk_clksel_r ? sow_pkg::SOW_SRC_EXTERNAL : sow_pkg::SOW_SRC_INTERNAL;
  assign wake.tick = wk_clksel_r ? ext_edge : int_tick;
  assign wake.period = wk_period_r;
  assign wake.restart = restart;

  sow_wakeup_div u_div
  (
    .clk_sys_i (clk_sys_i),
    .rst_b_i (rst_b_i),
    .ce_i (ce_i),
    .wake (wake.div)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt

  always_comb
  begin
    evt_set = 8'h00;
    evt_set[`SOW_EVT_WAKE] = wake.timeout;
    evt_set[`SOW_EVT_DISCARD] = wr_commit && sow_sel(paddr_i, `SOW_IDX_OPTIONS) && opt_written_r;
    evt_set[`SOW_EVT_BAD_STOP] = stop_request_i && !opt_r[`SOW_OPT_STOP];
  end

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      evt_status_r <= `SOW_EVT_RESET;
      evt_mask_r <= `SOW_EVT_RESET;
    end
    else if (ce_i)
    begin
      if (wr_commit && sow_sel(paddr_i, `SOW_IDX_EVT_STATUS))
      begin
        evt_status_r <= ((evt_status_r & ~wdat) | evt_set) & `SOW_EVT_IMPL;
      end
      else
      begin
        evt_status_r <= (evt_status_r | evt_set) & `SOW_EVT_IMPL;
      end
      if (wr_commit && sow_sel(paddr_i, `SOW_IDX_EVT_MASK))
      begin
        evt_mask_r <= wdat & `SOW_EVT_IMPL;
      end
    end
  end

  // interrupt levels
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      irq_r <= 1'b0;
      wakeup_irq_r <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_r <= |(evt_status_r & evt_mask_r);
      wakeup_irq_r <= wk_flag_r && wk_ie_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, stop and shared pin controls

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      wdog_cycles_r <= `SOW_WDOG_LONG_CYC;
      stop_enter_r <= 1'b0;
      bad_stop_r <= 1'b0;
    end
    else if (ce_i)
    begin
      wdog_cycles_r <= opt_r[`SOW_OPT_WDOG_LONG] ? `SOW_WDOG_LONG_CYC : `SOW_WDOG_SHORT_CYC;
      stop_enter_r <= stop_request_i && opt_r[`SOW_OPT_STOP];
      bad_stop_r <= stop_request_i && !opt_r[`SOW_OPT_STOP];
    end
  end

  // shared pin: debug function or output-only port bit
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      bdm_pin_o <= 1'b1;
    end
    else if (ce_i)
    begin
      if (opt_r[`SOW_OPT_DBG])
      begin
        pin_o <= bdm_out_i;
        pin_oe_o <= bdm_oe_i;
        bdm_pin_o <= pin_i;
      end
      else
      begin
        pin_o <= port_g_bit_zero_output_i;
        pin_oe_o <= 1'b1;
        bdm_pin_o <= 1'b1; // debug input idles high
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o = irq_r;
  assign wakeup_irq_o = wakeup_irq_r;
  assign watchdog_enable_o = opt_r[`SOW_OPT_WDOG_EN];
  assign watchdog_long_timeout_o = opt_r[`SOW_OPT_WDOG_LONG];
  assign watchdog_timeout_cycles_o = wdog_cycles_r;
  assign debug_pin_select_o = opt_r[`SOW_OPT_DBG];
  assign stop_enter_o = stop_enter_r;
  assign illegal_stop_reset_o = bad_stop_r;

endmodule : sow_top
`default_nettype wire

// [hw/sow_cfg.svh]
`ifndef SOW_CFG_SVH
`define SOW_CFG_SVH

// register indexes; the apb byte address is four times the index
`define SOW_IDX_OPTIONS 16'h1802
`define SOW_IDX_REV_HIGH 16'h1806
`define SOW_IDX_PART_LOW 16'h1807
`define SOW_IDX_WAKEUP 16'h1808
`define SOW_IDX_EVT_STATUS 16'h1809
`define SOW_IDX_EVT_MASK 16'h180a

// system options fields
`define SOW_OPT_WDOG_EN 7
`define SOW_OPT_WDOG_LONG 6
`define SOW_OPT_STOP 5
`define SOW_OPT_DBG 1
`define SOW_OPT_RESET 8'hc2
`define SOW_OPT_IMPL 8'he2

// wakeup status and control fields
`define SOW_WK_FLAG 7
`define SOW_WK_ACK 6
`define SOW_WK_CLKSEL 5
`define SOW_WK_IE 4
`define SOW_WK_PER_HI 2
`define SOW_WK_PER_LO 0
`define SOW_WK_RESET 8'h00

// event status and mask fields
`define SOW_EVT_WAKE 0
`define SOW_EVT_DISCARD 1
`define SOW_EVT_BAD_STOP 2
`define SOW_EVT_IMPL 8'h07
`define SOW_EVT_RESET 8'h00

// timing
`define SOW_CLK_PERIOD_NS 10
`define SOW_INT_TICK_NS 1000000
`define SOW_WDOG_SHORT_CYC 19'h02000
`define SOW_WDOG_LONG_CYC 19'h40000

// wakeup intervals: internal in ms ticks, external in source edges
`define SOW_INT_MS_1 16'd8
`define SOW_INT_MS_2 16'd32
`define SOW_INT_MS_3 16'd64
`define SOW_INT_MS_4 16'd128
`define SOW_INT_MS_5 16'd256
`define SOW_INT_MS_6 16'd512
`define SOW_INT_MS_7 16'd1024
`define SOW_EXT_DIV_1 16'd256
`define SOW_EXT_DIV_2 16'd1024
`define SOW_EXT_DIV_3 16'd2048
`define SOW_EXT_DIV_4 16'd4096
`define SOW_EXT_DIV_5 16'd8192
`define SOW_EXT_DIV_6 16'd16384
`define SOW_EXT_DIV_7 16'd32768

`endif

// [hw/sow_pkg.sv]
package sow_pkg;
  typedef logic [2:0] sow_period_t;
  typedef enum logic {SOW_SRC_INTERNAL, SOW_SRC_EXTERNAL} sow_src_t;
  typedef enum logic {SOW_APB_IDLE, SOW_APB_ANSWER} sow_apb_state_t;
endpackage : sow_pkg

// [hw/sow_wake_if.sv]
`timescale 1ns/10ps
`default_nettype none
// link between the register bank and the wakeup divider
interface sow_wake_if;
  logic tick;
  logic restart;
  sow_pkg::sow_src_t src;
  sow_pkg::sow_period_t period;
  logic timeout;
  modport ctl (output tick, output restart, output src, output period, input timeout);
  modport div (input tick, input restart, input src, input period, output timeout);
endinterface : sow_wake_if
`default_nettype wire

// [hw/sow_wakeup_div.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sow_cfg.svh"
module sow_wakeup_div
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  sow_wake_if.div wake
);

  logic [15:0] cnt_r;
  logic timeout_r;
  logic [15:0] limit;

  // number of ticks in one wakeup interval
  function automatic logic [15:0] sow_limit(input sow_pkg::sow_src_t src, input sow_pkg::sow_period_t per);
    logic [15:0] v;
    v = 16'h0000;
    if (src == sow_pkg::SOW_SRC_INTERNAL)
    begin
      case (per)
        3'h1: v = `SOW_INT_MS_1;
        3'h2: v = `SOW_INT_MS_2;
        3'h3: v = `SOW_INT_MS_3;
        3'h4: v = `SOW_INT_MS_4;
        3'h5: v = `SOW_INT_MS_5;
        3'h6: v = `SOW_INT_MS_6;
        3'h7: v = `SOW_INT_MS_7;
        default: v = 16'h0000;
      endcase
    end
    else
    begin
      case (per)
        3'h1: v = `SOW_EXT_DIV_1;
        3'h2: v = `SOW_EXT_DIV_2;
        3'h3: v = `SOW_EXT_DIV_3;
        3'h4: v = `SOW_EXT_DIV_4;
        3'h5: v = `SOW_EXT_DIV_5;
        3'h6: v = `SOW_EXT_DIV_6;
        3'h7: v = `SOW_EXT_DIV_7;
        default: v = 16'h0000;
      endcase
    end
    return v;
  endfunction : sow_limit

  assign limit = sow_limit(wake.src, wake.period);

  // interval counter; code zero holds it stopped, any source
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= 16'h0000;
      timeout_r <= 1'b0;
    end
    else if (ce_i)
    begin
      timeout_r <= 1'b0;
      if (wake.restart || (wake.period == 3'h0))
      begin
        cnt_r <= 16'h0000;
      end
      else if (wake.tick)
      begin
        if (cnt_r == limit - 16'h0001)
        begin
          cnt_r <= 16'h0000;
          timeout_r <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

  assign wake.timeout = timeout_r;

endmodule : sow_wakeup_div
`default_nettype wire

// [sim/sow_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module sow_top_sva
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic watchdog_enable_o,
  input wire logic watchdog_long_timeout_o,
  input wire logic [18:0] watchdog_timeout_cycles_o,
  input wire logic stop_request_i,
  input wire logic stop_enter_o,
  input wire logic illegal_stop_reset_o,
  input wire logic debug_pin_select_o,
  input wire logic port_g_bit_zero_output_i,
  input wire logic bdm_out_i,
  input wire logic bdm_oe_i,
  input wire logic pin_o,
  input wire logic pin_oe_o,
  input wire logic bdm_pin_o,
  input wire logic pin_i
);
  logic opt_wr;
  logic opt_seen_r;
  ////////////////////////////////////////////////////////////////
  // committed options write and whether one was already taken
  assign opt_wr = ce_i & psel_i & penable_i & pready_o & pwrite_i & (paddr_i == 16'h6008);
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      opt_seen_r <= 1'b0;
    else if (opt_wr)
      opt_seen_r <= 1'b1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////
  // bus answer timing
  a_apb_answer_next: assert property ($rose(psel_i && penable_i) |=> pready_o)
    else $error("no answer one cycle after access");
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response malformed");
  // options outputs
  a_opts_write_once: assert property (($changed(watchdog_enable_o) || $changed(watchdog_long_timeout_o)
    || $changed(debug_pin_select_o)) |-> $past(opt_wr) && !$past(opt_seen_r))
    else $error("options changed without a first write");
  a_wdog_cycles_map: assert property ($stable(watchdog_long_timeout_o) |->
    watchdog_timeout_cycles_o == (watchdog_long_timeout_o ? 19'h40000 : 19'h02000))
    else $error("watchdog length wrong");
  // stop handling; a request seen only while the clock enable is low goes unanswered
  a_stop_answer: assert property (ce_i && stop_request_i |=> stop_enter_o != illegal_stop_reset_o)
    else $error("stop request not answered");
  a_stop_cause: assert property ((stop_enter_o || illegal_stop_reset_o) |-> $past(stop_request_i))
    else $error("stop answer without request");
  // shared pin function; the reset release edge still loads reset values
  a_debug_pin_drive: assert property (rst_b_i && ce_i && debug_pin_select_o |=>
    pin_oe_o == $past(bdm_oe_i) && pin_o == $past(bdm_out_i))
    else $error("debug pin not driven by debug module");
  a_gpio_pin_drive: assert property (rst_b_i && ce_i && !debug_pin_select_o |=>
    pin_oe_o && pin_o == $past(port_g_bit_zero_output_i))
    else $error("output pin not driven by port data");
  a_debug_in_pass: assert property (rst_b_i && ce_i |=>
    bdm_pin_o == ($past(debug_pin_select_o) ? $past(pin_i) : 1'b1))
    else $error("debug input not passed from pin");
endmodule : sow_top_sva
bind sow_top sow_top_sva u_sva (.clk_sys_i, .rst_b_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .prdata_o, .pready_o, .pslverr_o, .watchdog_enable_o, .watchdog_long_timeout_o,
  .watchdog_timeout_cycles_o, .stop_request_i, .stop_enter_o, .illegal_stop_reset_o,
  .debug_pin_select_o, .port_g_bit_zero_output_i, .bdm_out_i, .bdm_oe_i, .pin_o, .pin_oe_o, .bdm_pin_o, .pin_i);
`default_nettype wire

// [sim/tb_sow_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "sow_cfg.svh"
module tb_sow_top;
  localparam int TICK = 10;
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  localparam logic [11:0] PN = 12'h3c1; // arbitrary value
  localparam logic [15:0] A_OPT = `SOW_IDX_OPTIONS << 2;
  localparam logic [15:0] A_REV = `SOW_IDX_REV_HIGH << 2;
  localparam logic [15:0] A_PNL = `SOW_IDX_PART_LOW << 2;
  localparam logic [15:0] A_WAK = `SOW_IDX_WAKEUP << 2;
  localparam logic [15:0] A_EVS = `SOW_IDX_EVT_STATUS << 2;
  localparam logic [15:0] A_EVM = `SOW_IDX_EVT_MASK << 2;
  logic clk_sys_i, rst_b_i, ce_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
  logic [15:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic watchdog_enable_o, watchdog_long_timeout_o, stop_request_i, stop_enter_o, illegal_stop_reset_o;
  logic [18:0] watchdog_timeout_cycles_o;
  logic ext_clk_i, wakeup_irq_o, debug_pin_select_o, port_g_bit_zero_output_i, bdm_out_i, bdm_oe_i;
  logic bdm_pin_o, pin_i, pin_o, pin_oe_o, ext_run;
  logic [32:0] exp_q[$];
  int fails = 0;
  int tests_run = 0;
  int int_ms[7] = '{8, 32, 64, 128, 256, 512, 1024};
  int ext_div[7] = '{256, 1024, 2048, 4096, 8192, 16384, 32768};

  sow_top #(.INT_TICK_CYCLES(TICK), .REVISION(REV), .PART_NUMBER(PN)) u_dut (.clk_sys_i, .rst_b_i, .ce_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o,
    .watchdog_enable_o, .watchdog_long_timeout_o, .watchdog_timeout_cycles_o, .stop_request_i,
    .stop_enter_o, .illegal_stop_reset_o, .ext_clk_i, .wakeup_irq_o, .debug_pin_select_o,
    .port_g_bit_zero_output_i, .bdm_out_i, .bdm_oe_i, .bdm_pin_o, .pin_i, .pin_o, .pin_oe_o);
  ////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // random pin traffic and the external wakeup source
  always @(posedge clk_sys_i)
  begin
    {pin_i, bdm_out_i, bdm_oe_i, port_g_bit_zero_output_i} <= 4'($urandom);
    ext_clk_i <= ext_run & ~ext_clk_i;
  end
  // bus answers compared against the oldest note
  always @(negedge clk_sys_i)
  begin
    if (pready_o === 1'b1)
      check({pslverr_o, prdata_o}, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("counts: %0d checks, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic give_up;
    check(33'h0, 33'h1);
    tally_and_finish();
  endtask : give_up
  // one apb transfer; e is the expected {pslverr, prdata}
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [32:0] e);
    int n = 0;
    exp_q.push_back(e);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
    if (n >= 50)
      give_up();
  endtask : apb
  task automatic do_reset;
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask : do_reset
  task automatic wait_wake(input int lim, output int n);
    n = 0;
    while (wakeup_irq_o !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= lim)
      give_up();
  endtask : wait_wake
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [7:0] opt;
    int n;
    int ex;
    {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, stop_request_i, ext_clk_i, ext_run} = '0;
    {ce_i, pin_i, bdm_out_i, bdm_oe_i, port_g_bit_zero_output_i} = 5'h10;
    void'($urandom(32'hb815d68e));
    for (int i = 0; i < 2; i++)
    begin
      do_reset();
      check({30'h0, watchdog_enable_o, watchdog_long_timeout_o, debug_pin_select_o}, 33'h7);
      apb(1'b0, A_OPT, 32'h0, 33'hc2);
      apb(1'b0, A_OPT, 32'h0, 33'hc2);
      apb(1'b0, A_REV, 32'h0, {25'h0, REV, PN[11:8]});
      apb(1'b0, A_PNL, 32'h0, {25'h0, PN[7:0]});
      apb(1'b0, A_WAK, 32'h0, 33'h0);
      opt = 8'($urandom);
      opt[5] = i[0];
      opt[1] = ~i[0];
      apb(1'b1, A_OPT, {24'($urandom), opt}, 33'h0);
      apb(1'b1, A_OPT, {24'h0, ~opt}, 33'h0);
      apb(1'b0, A_OPT, 32'h0, {25'h0, opt & 8'he2});
      check({30'h0, watchdog_enable_o, watchdog_long_timeout_o, debug_pin_select_o},
        {30'h0, opt[7], opt[6], opt[1]});
      check({14'h0, watchdog_timeout_cycles_o}, opt[6] ? 33'h40000 : 33'h02000);
      stop_request_i <= 1'b1;
      @(posedge clk_sys_i);
      stop_request_i <= 1'b0;
      @(posedge clk_sys_i);
      check({31'h0, stop_enter_o, illegal_stop_reset_o}, opt[5] ? 33'h2 : 33'h1);
      apb(1'b0, A_EVS, 32'h0, {30'h0, ~opt[5], 2'b10});
      check({32'h0, irq_o}, 33'h0);
      apb(1'b1, A_EVM, 32'h2, 33'h0);
      @(posedge clk_sys_i);
      check({32'h0, irq_o}, 33'h1);
      apb(1'b1, A_EVS, 32'h6, 33'h0);
      @(posedge clk_sys_i);
      check({32'h0, irq_o}, 33'h0);
      $display("test options pass %0d done", i);
    end
    // refused and ignored accesses
    apb(1'b0, 16'h6004, 32'h0, 33'h100000000);
    apb(1'b1, A_WAK, 32'hff08, 33'h0);
    apb(1'b1, A_WAK + 16'h2, 32'h17, 33'h100000000);
    apb(1'b0, A_WAK, 32'h0, 33'h0);
    $display("test refusals done");
    // wakeup intervals for every internal code, external codes one to three
    apb(1'b1, A_EVM, 32'h1, 33'h0);
    for (int s = 0; s < 2; s++)
      for (int c = 1; c < (s ? 4 : 8); c++)
      begin
        ext_run <= s[0];
        ex = s ? ext_div[c - 1] * 2 : int_ms[c - 1] * TICK;
        apb(1'b1, A_WAK, {26'h0, s[0], 2'b10, c[2:0]}, 33'h0);
        wait_wake(ex + 50, n);
        check({32'h0, n >= ex - 3 && n <= ex + 6}, 33'h1);
        check({32'h0, irq_o}, 33'h1);
        apb(1'b0, A_WAK, 32'h0, {25'h0, 2'b10, s[0], 2'b10, c[2:0]});
        apb(1'b1, A_WAK, {26'h1, s[0], 2'b10, c[2:0]}, 33'h0);
        apb(1'b1, A_EVS, 32'h1, 33'h0);
        apb(1'b0, A_WAK, 32'h0, {27'h0, s[0], 2'b10, c[2:0]});
        check({31'h0, irq_o, wakeup_irq_o}, 33'h0);
      end
    ext_run <= 1'b0;
    $display("test wakeup intervals done");
    // flag without request, then stopped timer
    apb(1'b1, A_WAK, 32'h01, 33'h0);
    repeat (120) @(posedge clk_sys_i);
    check({32'h0, wakeup_irq_o}, 33'h0);
    apb(1'b0, A_WAK, 32'h0, 33'h81);
    apb(1'b1, A_WAK, 32'h50, 33'h0);
    repeat (200) @(posedge clk_sys_i);
    apb(1'b0, A_WAK, 32'h0, 33'h10);
    $display("test wakeup disable done");
    // clock enable low freezes the stop answer
    ce_i <= 1'b0;
    stop_request_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    ce_i <= 1'b1;
    stop_request_i <= 1'b0;
    @(posedge clk_sys_i);
    check({31'h0, stop_enter_o, illegal_stop_reset_o}, 33'h0);
    $display("test clock enable done");
    tally_and_finish();
  end
endmodule : tb_sow_top
`default_nettype wire
